// >>> dv/rfsc_rx_model.sv
`timescale 1ns/100ps
module rfsc_rx_model
  import rfsc_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // Final frame status
  output rfsc_frame_t frame_out
);
  rfsc_frame_t pend_q[$];
  rfsc_frame_t inv;
  initial frame_out = '0;
  // One status per cycle; idle fields toggle so stale values never match
  always @(posedge clk_sys_in) begin
    if (pend_q.size() > 0) begin
      frame_out <= pend_q.pop_front();
    end else begin
      inv = ~frame_out;
      inv.valid = 1'b0;
      frame_out <= inv;
    end
  end
endmodule

// >>> dv/test_rfsc_stats.sv
`timescale 1ns/100ps
`include "rfsc_defs.svh"
module test_rfsc_stats
  import rfsc_pkg::*;
;
  localparam logic [7:0] AC = `RFSC_OFF_CTRL;
  localparam logic [7:0] AV = `RFSC_OFF_VLAN;
  localparam logic [7:0] AS = `RFSC_OFF_SNAP;
  localparam logic [15:0] T = 16'h0800;
  typedef struct {logic [32:0] v; logic rd; string nm;} rfsc_note_t;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pad = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  rfsc_frame_t frm;
  int err_total = 0;
  int checks_done = 0;
  int snaps = 0;
  rfsc_note_t nq[$];
  rfsc_note_t mn;
  logic [31:0] ec [9];
  logic [31:0] es [9];
  logic [13:0] c_max = 14'h05ee;
  logic c_sa = 1'b0;
  logic c_sv = 1'b0;
  logic c_sf = 1'b0;
  logic c_bc = 1'b1;
  logic c_sb = 1'b0;
  logic [15:0] c_vt = 16'h8100;
  logic [15:0] lf = 16'h0039;

  always #4 clk_sys_in = ~clk_sys_in;

  rfsc_stats rfsc_stats_inst (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .psel_in(psel),
    .penable_in(pen),
    .pwrite_in(pwr),
    .paddr_in(pad),
    .pwdata_in(pwd),
    .prdata_out(prd),
    .pready_out(prdy),
    .pslverr_out(perr),
    .frame_in(frm)
  );

  rfsc_rx_model rfsc_rx_model_inst (
    .clk_sys_in(clk_sys_in),
    .frame_out(frm)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic tmo();
    err_total++;
    final_report();
  endtask

  task automatic check(input string nm, input logic [32:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Completed transfer: oldest note against slave answer
  always @(posedge clk_sys_in) begin
    if (psel && pen && prdy === 1'b1) begin
      mn = nq.pop_front();
      if (mn.rd) check(mn.nm, {perr, prd}, mn.v);
      else check(mn.nm, {perr, 32'h0}, {mn.v[32], 32'h0});
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e,
                     input string nm);
    int k;
    nq.push_back('{e, !w, nm});
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwr <= w;
    pad <= a;
    pwd <= d;
    @(posedge clk_sys_in);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (prdy !== 1'b1 && k < 50);
    if (k >= 50) tmo();
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0, {1'b0, e}, nm);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, "write");
  endtask

  task automatic drain();
    int k;
    k = 0;
    while (rfsc_rx_model_inst.pend_q.size() > 0 && k < 5000) begin
      @(posedge clk_sys_in);
      k++;
    end
    if (k >= 5000) tmo();
    repeat (3) @(posedge clk_sys_in);
  endtask

  task automatic setcfg(input logic lt);
    drain();
    wr(AC, {lt, 10'h0, c_sb, c_bc, c_sf, c_sv, c_sa, 2'h0, c_max});
  endtask

  task automatic send(input logic [15:0] len, t1, t2,
                      input logic [7:0] fl);
    logic [1:0] nt;
    logic [15:0] mx;
    logic [15:0] b;
    logic er;
    logic sh;
    logic lg;
    logic ok;
    nt = 2'h0;
    if (t1 == 16'h8100 || t1 == c_vt)
      nt = (t2 == 16'h8100 || t2 == c_vt) ? 2'h2 : 2'h1;
    mx = {2'h0, c_max} + (c_sa ? {12'h0, nt, 2'h0} : 16'h0);
    er = fl[7] | fl[6];
    sh = len < 16'h0040;
    lg = len > mx;
    ok = !er && !fl[5] && !sh && !lg;
    b = len - (c_sv ? {12'h0, nt, 2'h0} : 16'h0) -
        {13'h0, c_sf, 2'h0};
    ec[0] += 32'(er && !sh && !lg);
    ec[1] += 32'(fl[5]);
    ec[2] += 32'(er && sh);
    ec[3] += 32'(er && lg);
    ec[4] += 32'(!er && !fl[5] && sh);
    ec[5] += 32'(!er && !fl[5] && lg);
    ec[6] += 32'(fl[4] && (ok || c_sb));
    if (ok && !fl[4] && fl[1] && !fl[3] && !fl[2])
      ec[7] += 32'(b);
    if (ok && !fl[4] && fl[0] && c_bc) ec[8] += 32'(b);
    rfsc_rx_model_inst.pend_q.push_back({1'b1, len, t1, t2, fl});
  endtask

  task automatic snapchk(input logic take, input logic cnt);
    if (take) begin
      drain();
      wr(AS, 32'h0);
      es = ec;
      snaps++;
    end
    if (cnt) rd(AS, 32'(snaps), "snap_count");
    for (int i = 0; i < 9; i++)
      rd(`RFSC_OFF_CNT0 + 8'(i * 4),
         es[i] & (i < 7 ? 32'h000fffff : 32'hffffffff),
         $sformatf("cnt%0d", i));
  endtask

  function automatic logic [15:0] nx(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction

  initial begin
    repeat (90000) @(posedge clk_sys_in);
    tmo();
  end

  initial begin
    ec = '{default: 32'h0};
    es = ec;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(AC, 32'h000805ee, "ctrl");
    rd(AV, 32'h00008100, "vlan");
    rd(AS, 32'h0, "snap_count");
    apb(1'b0, 8'h30, 32'h0, 33'h100000000, "unmapped_rd");
    apb(1'b1, 8'h30, 32'hffffffff, 33'h100000000, "unmapped_wr");
    $display("test registers done");
    send(16'h0064, T, T, 8'h82);
    send(16'h0064, T, T, 8'h41);
    send(16'h05ef, T, T, 8'h80);
    send(16'h05ee, T, T, 8'h80);
    send(16'h05ff, T, T, 8'h40);
    send(16'h003f, T, T, 8'h80);
    send(16'h003f, T, T, 8'h40);
    send(16'h0040, T, T, 8'h82);
    send(16'h0064, T, T, 8'h20);
    send(16'h003f, T, T, 8'h02);
    send(16'h05ef, T, T, 8'h02);
    send(16'h05ee, T, T, 8'h02);
    send(16'h0040, T, T, 8'h01);
    send(16'h0064, T, T, 8'h12);
    send(16'h0064, T, T, 8'h92);
    send(16'h0064, T, T, 8'h0a);
    send(16'h0064, T, T, 8'h06);
    snapchk(1'b1, 1'b1);
    $display("test error classes done");
    c_sa = 1'b1;
    c_vt = 16'h9100;
    wr(AV, {16'h0, c_vt});
    rd(AV, {16'h0, c_vt}, "vlan");
    setcfg(1'b0);
    send(16'h05f2, 16'h8100, T, 8'h02);
    send(16'h05f3, 16'h8100, T, 8'h02);
    send(16'h05f6, 16'h9100, 16'h8100, 8'h02);
    send(16'h05f7, 16'h9100, 16'h9100, 8'h02);
    send(16'h05f2, T, T, 8'h02);
    c_sv = 1'b1;
    c_sf = 1'b1;
    setcfg(1'b0);
    send(16'h00c8, 16'h8100, T, 8'h02);
    send(16'h00c8, T, T, 8'h01);
    c_bc = 1'b0;
    c_sb = 1'b1;
    setcfg(1'b0);
    send(16'h00c8, T, T, 8'h01);
    send(16'h0064, T, T, 8'h92);
    snapchk(1'b1, 1'b1);
    send(16'h0064, T, T, 8'h82);
    send(16'h00c8, T, T, 8'h02);
    drain();
    snapchk(1'b0, 1'b0);
    $display("test vlan strip snapshot done");
    c_bc = 1'b1;
    c_sv = 1'b0;
    setcfg(1'b0);
    for (int i = 0; i < 200; i++) begin
      lf = nx(lf);
      send(16'h0030 + {5'h0, lf[10:0]}, lf[12] ? 16'h8100 : T,
           lf[9] ? 16'h9100 : T,
           {lf[13], lf[14] & lf[15], 4'h0, lf[11], !lf[11]});
    end
    snapchk(1'b1, 1'b1);
    $display("test random frames done");
    setcfg(1'b1);
    ec = '{default: 32'h0};
    snaps = 0;
    rd(AC, {11'h0, c_sb, c_bc, c_sf, c_sv, c_sa, 2'h0, c_max}, "ctrl");
    snapchk(1'b1, 1'b1);
    send(16'h0064, T, T, 8'h82);
    drain();
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    ec = '{default: 32'h0};
    snaps = 0;
    rd(AC, 32'h000805ee, "ctrl");
    snapchk(1'b1, 1'b1);
    $display("test resets done");
    final_report();
  end
endmodule

// >>> rtl/rfsc_classify.sv
`timescale 1ns/100ps
`include "rfsc_defs.svh"
module rfsc_classify
  import rfsc_pkg::*;
(
  // Frame status and settings
  input wire rfsc_frame_t frame_in,
  input wire rfsc_cfg_t cfg_in,
  input wire logic [15:0] vlan_ethertype_value_in,
  // Counter updates
  output rfsc_upd_t upd_out
);
  logic tag1;
  logic tag2;
  logic [15:0] tag_bytes;
  logic [15:0] limit;
  logic over_len;
  logic short_len;
  logic crc_bad;
  logic any_err;
  logic jab;
  logic frag;
  logic good;
  logic v;

  always_comb begin
    v = frame_in.valid;
    tag1 = (frame_in.type1 == `RFSC_TPID_VLAN) ||
           (frame_in.type1 == vlan_ethertype_value_in);
    tag2 = tag1 && ((frame_in.type2 == `RFSC_TPID_VLAN) ||
           (frame_in.type2 == vlan_ethertype_value_in));
    tag_bytes = {12'h000, tag1 & tag2, tag1 ^ tag2, 2'b00};
    limit = {2'b00, cfg_in.max_size} +
            (cfg_in.size_allow ? tag_bytes : 16'h0000);
    // Length is whole bytes, so stray bits never qualify
    over_len = frame_in.len > limit;
    short_len = frame_in.len < `RFSC_MIN_FRAME;
    crc_bad = frame_in.fcs_err | frame_in.rx_err;
    any_err = crc_bad | frame_in.align_err;
    jab = over_len & crc_bad;
    frag = short_len & crc_bad;
    good = !any_err && !short_len && !over_len;
    upd_out = '0;
    upd_out.inc[`RFSC_IDX_FCS] = v & crc_bad & !jab &
      !frag;
    upd_out.inc[`RFSC_IDX_ALIGN] = v & frame_in.align_err;
    upd_out.inc[`RFSC_IDX_FRAG] = v & frag;
    upd_out.inc[`RFSC_IDX_JAB] = v & jab;
    upd_out.inc[`RFSC_IDX_UNDER] = v & short_len & !any_err;
    upd_out.inc[`RFSC_IDX_OVER] = v & over_len & !any_err;
    upd_out.inc[`RFSC_IDX_DROP] = v & frame_in.dropped &
      (good | cfg_in.store_bad);
    upd_out.inc[`RFSC_IDX_UCB] = v & good & frame_in.ucast &
      !frame_in.filt_fail & !frame_in.pause_filt &
      !frame_in.dropped;
    upd_out.inc[`RFSC_IDX_BCB] = v & good & frame_in.bcast &
      cfg_in.accept_bcast & !frame_in.dropped;
    upd_out.bytes = frame_in.len -
      (cfg_in.strip_vlan ? tag_bytes : 16'h0000) -
      (cfg_in.strip_fcs ? `RFSC_FCS_BYTES : 16'h0000);
  end
endmodule

// >>> rtl/rfsc_counter.sv
`timescale 1ns/100ps
`include "rfsc_defs.svh"
module rfsc_counter
  import rfsc_pkg::*;
#(
  parameter int WIDTH = 20
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Update
  input wire logic clr_in,
  input wire logic inc_in,
  input wire logic [15:0] add_in,
  // Value
  output logic [WIDTH-1:0] count_out
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } rfsc_cnt_t;

  rfsc_cnt_t s_r;
  rfsc_cnt_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (clr_in) begin
      s_nxt.cnt = '0;
    end else if (inc_in) begin
      s_nxt.cnt = s_r.cnt + WIDTH'(add_in);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count_out = s_r.cnt;
endmodule

// >>> rtl/rfsc_defs.svh
`ifndef RFSC_DEFS_SVH
`define RFSC_DEFS_SVH

// Register byte offsets
`define RFSC_OFF_CTRL 8'h00
`define RFSC_OFF_VLAN 8'h04
`define RFSC_OFF_SNAP 8'h08
`define RFSC_OFF_CNT0 8'h40

// Control register fields
`define RFSC_CTRL_MAX_LSB 0
`define RFSC_CTRL_MAX_MSB 13
`define RFSC_CTRL_SIZE_ALLOW 16
`define RFSC_CTRL_STRIP_VLAN 17
`define RFSC_CTRL_STRIP_FCS 18
`define RFSC_CTRL_ACCEPT_BC 19
`define RFSC_CTRL_STORE_BAD 20
`define RFSC_CTRL_LITE_RST 31

// Reset values
`define RFSC_MAX_SIZE_RST 14'h05ee
`define RFSC_ACCEPT_BC_RST 1'b1
`define RFSC_VLAN_ETYPE_RST 16'h8100

// Frame constants
`define RFSC_TPID_VLAN 16'h8100
`define RFSC_MIN_FRAME 16'h0040
`define RFSC_FCS_BYTES 16'h0004

// Counter indices
`define RFSC_IDX_FCS 0
`define RFSC_IDX_ALIGN 1
`define RFSC_IDX_FRAG 2
`define RFSC_IDX_JAB 3
`define RFSC_IDX_UNDER 4
`define RFSC_IDX_OVER 5
`define RFSC_IDX_DROP 6
`define RFSC_IDX_UCB 7
`define RFSC_IDX_BCB 8
`define RFSC_NUM_EVT 7
`define RFSC_NUM_CNT 9

`endif

// >>> rtl/rfsc_pkg.sv
package rfsc_pkg;

  // Final per-frame status from the receive path
  typedef struct packed {
    logic valid;
    logic [15:0] len;
    logic [15:0] type1;
    logic [15:0] type2;
    logic fcs_err;
    logic rx_err;
    logic align_err;
    logic dropped;
    logic filt_fail;
    logic pause_filt;
    logic ucast;
    logic bcast;
  } rfsc_frame_t;

  typedef struct packed {
    logic [13:0] max_size;
    logic size_allow;
    logic strip_vlan;
    logic strip_fcs;
    logic accept_bcast;
    logic store_bad;
  } rfsc_cfg_t;

  // Increment strobes per counter index and byte amount
  typedef struct packed {
    logic [8:0] inc;
    logic [15:0] bytes;
  } rfsc_upd_t;

  typedef struct packed {
    rfsc_cfg_t cfg;
    logic [15:0] vlan_ethertype_value;
    logic lite_clr;
    logic [8:0][31:0] snap;
    logic [31:0] snap_cnt;
    logic [31:0] rdata;
  } rfsc_main_t;

endpackage

// >>> rtl/rfsc_stats.sv
// Contract
// - 20-bit counter of frames with CRC or line receive errors
// - Jabber plus FCS error counts only as jabber
// - Short frame with FCS error counts only as fragment
// - 20-bit counter of frames with alignment errors
// - 20-bit fragment counter: under 64 bytes with FCS or receive error
// - 20-bit jabber counter: over max length with FCS or receive error
// - Jabber needs a whole extra byte beyond maximum length
// - 20-bit undersize counter: under 64 bytes, no other error
// - 20-bit oversize counter: error-free frames above maximum length
// - Size allowance adds 4 bytes per tag, 8 for stacked
// - Tag present when type is 8100h or programmed ethertype
// - Oversize needs a whole extra byte beyond maximum length
// - 20-bit counter of frames dropped for lack of FIFO room
// - Errored drop counts as error; as drop only if storing bad
// - 32-bit unicast good byte total, filtered and lost excluded
// - Byte count omits stripped tag and stripped FCS
// - 32-bit broadcast good byte total, skip unaccepted and lost
// - Counters wrap to zero past maximum
// - Every reset, lite reset too, clears all counters
// - A write to the snapshot register captures one consistent snapshot
`timescale 1ns/100ps
`include "rfsc_defs.svh"
module rfsc_stats
  import rfsc_pkg::*;
#(
  parameter int EVT_W = 20,
  parameter int BYTE_W = 32
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Receive frame status
  input wire rfsc_frame_t frame_in
);
  rfsc_main_t s_r;
  rfsc_main_t s_nxt;
  rfsc_upd_t upd;
  logic [8:0][31:0] cnt;
  logic cnt_clr;
  logic setup;
  logic acc;
  logic [7:0] coff;
  logic is_cnt;
  logic mapped;
  logic snap_wr;
  logic [31:0] rd;

  rfsc_classify u_classify (
    .frame_in(frame_in),
    .cfg_in(s_r.cfg),
    .vlan_ethertype_value_in(s_r.vlan_ethertype_value),
    .upd_out(upd)
  );

  assign cnt_clr = s_r.lite_clr;

  for (genvar i = 0; i < `RFSC_NUM_CNT; i++) begin : g_cnt
    localparam int W = (i < `RFSC_NUM_EVT) ? EVT_W : BYTE_W;
    logic [W-1:0] cw;
    rfsc_counter #(
      .WIDTH(W)
    ) u_counter (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .clr_in(cnt_clr),
      .inc_in(upd.inc[i]),
      .add_in((i < `RFSC_NUM_EVT) ? 16'h0001 : upd.bytes),
      .count_out(cw)
    );
    assign cnt[i] = 32'(cw);
  end

  // APB decode
  always_comb begin
    setup = psel_in && !penable_in;
    acc = psel_in && penable_in;
    coff = paddr_in - `RFSC_OFF_CNT0;
    is_cnt = (paddr_in >= `RFSC_OFF_CNT0) && (coff[1:0] == 2'b00) &&
             (coff[7:2] < 6'(`RFSC_NUM_CNT));
    mapped = is_cnt || (paddr_in == `RFSC_OFF_CTRL) ||
             (paddr_in == `RFSC_OFF_VLAN) || (paddr_in == `RFSC_OFF_SNAP);
    snap_wr = acc && pwrite_in && (paddr_in == `RFSC_OFF_SNAP);
  end

  // Read mux; counter words come from the snapshot only
  always_comb begin
    rd = '0;
    if (is_cnt) begin
      rd = s_r.snap[coff[5:2]];
    end else if (paddr_in == `RFSC_OFF_CTRL) begin
      rd[`RFSC_CTRL_MAX_MSB:`RFSC_CTRL_MAX_LSB] = s_r.cfg.max_size;
      rd[`RFSC_CTRL_SIZE_ALLOW] = s_r.cfg.size_allow;
      rd[`RFSC_CTRL_STRIP_VLAN] = s_r.cfg.strip_vlan;
      rd[`RFSC_CTRL_STRIP_FCS] = s_r.cfg.strip_fcs;
      rd[`RFSC_CTRL_ACCEPT_BC] = s_r.cfg.accept_bcast;
      rd[`RFSC_CTRL_STORE_BAD] = s_r.cfg.store_bad;
    end else if (paddr_in == `RFSC_OFF_VLAN) begin
      rd[15:0] = s_r.vlan_ethertype_value;
    end else if (paddr_in == `RFSC_OFF_SNAP) begin
      rd = s_r.snap_cnt;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.lite_clr = 1'b0;
    if (setup) begin
      s_nxt.rdata = rd;
    end
    if (acc && pwrite_in && paddr_in == `RFSC_OFF_CTRL) begin
      s_nxt.cfg.max_size =
        pwdata_in[`RFSC_CTRL_MAX_MSB:`RFSC_CTRL_MAX_LSB];
      s_nxt.cfg.size_allow = pwdata_in[`RFSC_CTRL_SIZE_ALLOW];
      s_nxt.cfg.strip_vlan = pwdata_in[`RFSC_CTRL_STRIP_VLAN];
      s_nxt.cfg.strip_fcs = pwdata_in[`RFSC_CTRL_STRIP_FCS];
      s_nxt.cfg.accept_bcast = pwdata_in[`RFSC_CTRL_ACCEPT_BC];
      s_nxt.cfg.store_bad = pwdata_in[`RFSC_CTRL_STORE_BAD];
      s_nxt.lite_clr = pwdata_in[`RFSC_CTRL_LITE_RST];
    end
    if (acc && pwrite_in && paddr_in == `RFSC_OFF_VLAN) begin
      s_nxt.vlan_ethertype_value = pwdata_in[15:0];
    end
    // All counters captured at one edge
    if (snap_wr) begin
      s_nxt.snap = cnt;
      s_nxt.snap_cnt = s_r.snap_cnt + 32'h1;
    end
    if (s_r.lite_clr) begin
      s_nxt.snap = '0;
      s_nxt.snap_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
      s_r.cfg.max_size <= `RFSC_MAX_SIZE_RST;
      s_r.cfg.accept_bcast <= `RFSC_ACCEPT_BC_RST;
      s_r.vlan_ethertype_value <= `RFSC_VLAN_ETYPE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_out = s_r.rdata;
  assign pready_out = 1'b1;
  assign pslverr_out = acc && !mapped;

  // Checks
  a_fcs_counts: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && frame_in.rx_err && !s_r.lite_clr &&
     frame_in.len >= `RFSC_MIN_FRAME &&
     frame_in.len <= {2'b00, s_r.cfg.max_size})
    |=> cnt[`RFSC_IDX_FCS][19:0] ==
        20'($past(cnt[`RFSC_IDX_FCS][19:0]) + 20'h1))
    else $error("fcs counter missed an error frame");

  a_jabber_wins: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && frame_in.fcs_err && !s_r.lite_clr &&
     frame_in.len > ({2'b00, s_r.cfg.max_size} + 16'h0008))
    |=> (cnt[`RFSC_IDX_JAB][19:0] ==
         20'($past(cnt[`RFSC_IDX_JAB][19:0]) + 20'h1)) &&
        $stable(cnt[`RFSC_IDX_FCS]))
    else $error("jabber frame not counted as jabber only");

  a_frag_wins: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && frame_in.fcs_err && !s_r.lite_clr &&
     frame_in.len < `RFSC_MIN_FRAME)
    |=> (cnt[`RFSC_IDX_FRAG][19:0] ==
         20'($past(cnt[`RFSC_IDX_FRAG][19:0]) + 20'h1)) &&
        $stable(cnt[`RFSC_IDX_FCS]) && $stable(cnt[`RFSC_IDX_UNDER]))
    else $error("short bad frame not counted as fragment only");

  a_align_count: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && frame_in.align_err && !s_r.lite_clr)
    |=> cnt[`RFSC_IDX_ALIGN][19:0] ==
        20'($past(cnt[`RFSC_IDX_ALIGN][19:0]) + 20'h1))
    else $error("alignment counter missed a frame");

  a_under_count: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && !frame_in.fcs_err && !frame_in.rx_err &&
     !frame_in.align_err && !s_r.lite_clr &&
     frame_in.len < `RFSC_MIN_FRAME)
    |=> (cnt[`RFSC_IDX_UNDER][19:0] ==
         20'($past(cnt[`RFSC_IDX_UNDER][19:0]) + 20'h1)) &&
        $stable(cnt[`RFSC_IDX_FRAG]))
    else $error("undersize counter missed a clean short frame");

  a_over_vlan: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && !frame_in.fcs_err && !frame_in.rx_err &&
     !frame_in.align_err && !s_r.lite_clr && s_r.cfg.size_allow &&
     frame_in.type1 == `RFSC_TPID_VLAN &&
     frame_in.type2 != `RFSC_TPID_VLAN &&
     frame_in.type2 != s_r.vlan_ethertype_value &&
     frame_in.len == ({2'b00, s_r.cfg.max_size} + 16'h0004))
    |=> $stable(cnt[`RFSC_IDX_OVER]))
    else $error("tagged frame within allowance counted oversize");

  a_over_byte: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && !frame_in.fcs_err && !frame_in.rx_err &&
     !frame_in.align_err && !s_r.lite_clr && !s_r.cfg.size_allow &&
     frame_in.len == ({2'b00, s_r.cfg.max_size} + 16'h0001))
    |=> cnt[`RFSC_IDX_OVER][19:0] ==
        20'($past(cnt[`RFSC_IDX_OVER][19:0]) + 20'h1))
    else $error("one byte over maximum not counted oversize");

  a_drop_bad: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && frame_in.dropped && frame_in.fcs_err &&
     !s_r.cfg.store_bad && !s_r.lite_clr)
    |=> $stable(cnt[`RFSC_IDX_DROP]))
    else $error("bad dropped frame counted while not storing bad");

  a_ucast_bytes: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (upd.inc[`RFSC_IDX_UCB] && s_r.cfg.strip_fcs &&
     !s_r.cfg.strip_vlan && !s_r.lite_clr)
    |=> cnt[`RFSC_IDX_UCB] == $past(cnt[`RFSC_IDX_UCB]) +
        32'($past(frame_in.len)) - 32'h4)
    else $error("unicast byte total wrong with fcs stripped");

  a_bcast_block: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && frame_in.bcast && !s_r.cfg.accept_bcast &&
     !s_r.lite_clr)
    |=> $stable(cnt[`RFSC_IDX_BCB]))
    else $error("broadcast bytes counted while not accepted");

  a_lite_clear: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    s_r.lite_clr |=> (cnt == '0) && (s_r.snap == '0))
    else $error("lite reset left a counter nonzero");

  a_snap_hold: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    snap_wr && !s_r.lite_clr
    |=> (s_r.snap == $past(cnt)) [*1] ##1
        ($stable(s_r.snap) || $past(snap_wr) || $past(s_r.lite_clr)))
    else $error("snapshot not a one-edge copy of counters");

  a_one_update: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (!frame_in.valid && !s_r.lite_clr) |=> $stable(cnt))
    else $error("counter moved without final frame status");

  a_frag_rx: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && frame_in.rx_err && !frame_in.fcs_err &&
     !s_r.lite_clr && frame_in.len < `RFSC_MIN_FRAME)
    |=> cnt[`RFSC_IDX_FRAG][19:0] ==
        20'($past(cnt[`RFSC_IDX_FRAG][19:0]) + 20'h1))
    else $error("fragment counter missed a short receive error");

  a_jab_rx: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && frame_in.rx_err && !s_r.lite_clr &&
     frame_in.len > ({2'b00, s_r.cfg.max_size} + 16'h0008))
    |=> cnt[`RFSC_IDX_JAB][19:0] ==
        20'($past(cnt[`RFSC_IDX_JAB][19:0]) + 20'h1))
    else $error("jabber counter missed a long receive error");

  a_jab_edge: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && frame_in.fcs_err && !s_r.lite_clr &&
     frame_in.len == {2'b00, s_r.cfg.max_size})
    |=> $stable(cnt[`RFSC_IDX_JAB]))
    else $error("frame at maximum length counted as jabber");

  a_over_clean: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && !frame_in.fcs_err && !frame_in.rx_err &&
     !frame_in.align_err && !s_r.lite_clr &&
     frame_in.len > ({2'b00, s_r.cfg.max_size} + 16'h0008))
    |=> (cnt[`RFSC_IDX_OVER][19:0] ==
         20'($past(cnt[`RFSC_IDX_OVER][19:0]) + 20'h1)) &&
        $stable(cnt[`RFSC_IDX_JAB]))
    else $error("oversize counter missed a clean long frame");

  a_tag_stacked: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && !frame_in.fcs_err && !frame_in.rx_err &&
     !frame_in.align_err && !s_r.lite_clr && s_r.cfg.size_allow &&
     frame_in.type1 == s_r.vlan_ethertype_value &&
     (frame_in.type2 == `RFSC_TPID_VLAN ||
      frame_in.type2 == s_r.vlan_ethertype_value) &&
     frame_in.len == ({2'b00, s_r.cfg.max_size} + 16'h0008))
    |=> $stable(cnt[`RFSC_IDX_OVER]))
    else $error("stacked programmed tags counted oversize");

  a_drop_count: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && frame_in.dropped && !frame_in.fcs_err &&
     !frame_in.rx_err && !frame_in.align_err && !s_r.lite_clr &&
     frame_in.len >= `RFSC_MIN_FRAME &&
     frame_in.len <= {2'b00, s_r.cfg.max_size})
    |=> cnt[`RFSC_IDX_DROP][19:0] ==
        20'($past(cnt[`RFSC_IDX_DROP][19:0]) + 20'h1))
    else $error("dropped counter missed a clean lost frame");

  a_ucast_skip: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (frame_in.valid && !s_r.lite_clr && (frame_in.filt_fail ||
     frame_in.pause_filt || frame_in.dropped))
    |=> $stable(cnt[`RFSC_IDX_UCB]))
    else $error("filtered or lost frame added to unicast bytes");
endmodule
